// file: logic/odp_params.svh
`ifndef ODP_PARAMS_SVH
`define ODP_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ODP_IDX_OUT_LO      6'h00
`define ODP_IDX_OUT_HI      6'h02
`define ODP_IDX_DIR_LO      6'h04
`define ODP_IDX_DIR_HI      6'h06
`define ODP_IDX_CTRL        6'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define ODP_CTRL_DBL_BUF    0
`define ODP_CTRL_CLK_POL    1
`define ODP_CTRL_MODE_EN    2
`define ODP_CTRL_MASTER     3
`define ODP_CTRL_WIDTH      4

// ****************************************************************
// Reset values and line positions
// ****************************************************************
`define ODP_LATCH_RST       24'hFFFFFF
`define ODP_CTRL_RST        4'h0
`define ODP_NUM_LINES       24
`define ODP_MCLK_OUT_LINE   22
`define ODP_MCLK_IN_LINE    23
`define ODP_LO_WIDTH        16
`define ODP_HI_WIDTH        8
`define ODP_SYNC_STAGES     2

// ****************************************************************
// Timing
// ****************************************************************
`define ODP_REF_CLK_NS      50
`define ODP_EXT_CLK_MIN_NS  1000
`define ODP_EXT_CLK_CYCLES  (`ODP_EXT_CLK_MIN_NS / `ODP_REF_CLK_NS)

`endif

// file: logic/odp_pkg.sv
`default_nettype none
package odp_pkg;

    // ****************************************************************
    // Control register carrier
    // ****************************************************************
    typedef struct packed {
        logic master_sel;
        logic mode_en;
        logic clk_pol;
        logic dbl_buf;
    } odp_ctrl_s;

    typedef logic [23:0] odp_lines_t;

endpackage : odp_pkg
`default_nettype wire

// file: logic/odp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module odp_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    // Clock and control
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             ce,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage [STAGES];

    generate
        if (STAGES < 2)
        begin : g_bad
            $error("odp_sync needs at least two stages");
        end
    endgenerate

    // Reset clears to zero; first stage feeds only the next stage
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < STAGES; i++)
                stage[i] <= '0;
        end
        else if (ce)
        begin
            stage[0] <= async_in;
            for (int i = 1; i < STAGES; i++)
                stage[i] <= stage[i-1];
        end
    end

    assign sync_out = stage[STAGES-1];

endmodule : odp_sync
`default_nettype wire

// file: logic/odp_port.sv
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "odp_params.svh"

// How it works
// - Each of the 24 lines, save line 23 while master in master/slave mode, acts as input or output purely by what software puts in its latch.
// - A latch bit of one turns the low-side driver off so the pull-up sets the pin high.
// - A latch bit of zero turns the driver on and pulls the pin low.
// - Reset sets every latch bit to one so all drivers start off.
// - With double buffering on, values latch on an external clock of at most 1 MHz.
// - A polarity bit picks the rising or the falling external edge for latching.
// - The first location takes output writes and reads back the latch.
// - A second read-only location returns the level on the pins, sampled only at the latch edge while double buffering is on.
// - The master in master/slave mode re-drives the external clock on line 23.
// - Registers accept both 16-bit word and 8-bit byte accesses.
// - Control holds double buffer, polarity, mode enable and master select; upper bits read zero.
// - In the word for lines 17 to 24, bits 15 to 8 are ignored on write and read as zero.
module odp_port #(
    parameter int NLINES = `ODP_NUM_LINES,
    parameter int STAGES = `ODP_SYNC_STAGES
) (
    // Clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 ce,
    // External latch clock
    input  wire logic                 ext_clk,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Field pins
    input  wire odp_pkg::odp_lines_t  pin_in,
    output odp_pkg::odp_lines_t       pin_out,
    output odp_pkg::odp_lines_t       pin_oe
);
    import odp_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    generate
        if (NLINES != `ODP_NUM_LINES)
        begin : g_bad_lines
            $error("odp_port register map serves exactly 24 lines");
        end
        if (STAGES < 2)
        begin : g_bad_stages
            $error("odp_port needs at least two synchroniser stages");
        end
    endgenerate

    // ****************************************************************
    // Declarations
    // ****************************************************************
    odp_lines_t       latch;
    odp_lines_t       drive;
    odp_lines_t       din;
    odp_lines_t       pin_s;
    odp_ctrl_s        ctrl;
    logic             tog_rise;
    logic             tog_fall;
    logic [1:0]       ext_rst;
    logic             tog_rise_s;
    logic             tog_fall_s;
    logic             ext_lvl_s;
    logic             src_prev;
    logic             src_cur;
    logic             strobe;
    logic             prep;
    logic             mclk_oe;
    logic             setup;
    logic             wr_done;
    logic [5:0]       idx;
    logic [31:0]      next_rdata;
    logic             next_err;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
        logic [15:0] r;
        r = old_v;
        if (strb[0])
            r[7:0] = new_v[7:0];
        if (strb[1])
            r[15:8] = new_v[15:8];
        return r;
    endfunction : merge16

    function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_idx);
        return a == reg_idx;
    endfunction : hit

    // ****************************************************************
    // External clock domain
    // ****************************************************************
    // Reset reaches this domain through two flops; the clock may stop,
    // so only the edge toggles live here.
    always_ff @(posedge ext_clk)
    begin
        ext_rst <= {ext_rst[0], srst};
    end

    always_ff @(posedge ext_clk)
    begin
        if (ext_rst[1])
            tog_rise <= 1'b0;
        else
            tog_rise <= ~tog_rise;
    end

    always_ff @(negedge ext_clk)
    begin
        if (ext_rst[1])
            tog_fall <= 1'b0;
        else
            tog_fall <= ~tog_fall;
    end

    // ****************************************************************
    // Crossing into the bus clock
    // ****************************************************************
    odp_sync #(
        .WIDTH  (NLINES + 3),
        .STAGES (STAGES)
    ) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ce       (ce),
        .async_in ({ext_clk, tog_fall, tog_rise, pin_in}),
        .sync_out ({ext_lvl_s, tog_fall_s, tog_rise_s, pin_s})
    );

    // ****************************************************************
    // Latch edge detection
    // ****************************************************************
    // In master/slave mode every module latches on the shared clock at
    // line 24; otherwise the chosen ext_clk toggle is watched.
    always_comb
    begin
        if (ctrl.mode_en)
            src_cur = pin_s[`ODP_MCLK_IN_LINE];
        else if (ctrl.clk_pol)
            src_cur = tog_fall_s;
        else
            src_cur = tog_rise_s;
    end

    always_comb
    begin
        if (!ctrl.mode_en)
            strobe = src_cur ^ src_prev;
        else if (ctrl.clk_pol)
            strobe = src_prev & ~src_cur;
        else
            strobe = ~src_prev & src_cur;
    end

    // History loads the live value during reset so release gives no false edge
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            src_prev <= src_cur;
        else if (ce)
            src_prev <= src_cur;
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign idx     = paddr[7:2];
    assign setup   = psel & ~prep;
    assign pready  = psel & penable & prep & ce;
    assign wr_done = pready & pwrite & ~pslverr;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (hit(idx, `ODP_IDX_OUT_LO))
            next_rdata[15:0] = latch[15:0];
        else if (hit(idx, `ODP_IDX_OUT_HI))
            next_rdata[7:0] = latch[23:16];
        else if (hit(idx, `ODP_IDX_DIR_LO) && !pwrite)
            next_rdata[15:0] = din[15:0];
        else if (hit(idx, `ODP_IDX_DIR_HI) && !pwrite)
            next_rdata[7:0] = din[23:16];
        else if (hit(idx, `ODP_IDX_CTRL))
            next_rdata[`ODP_CTRL_WIDTH-1:0] = ctrl;
        else
            next_err = 1'b1;
    end

    // Read data and error are taken once per transfer, so a stall on ce
    // cannot leave a stale answer.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prep    <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            if (setup)
            begin
                prep    <= 1'b1;
                prdata  <= next_rdata;
                pslverr <= next_err;
            end
            else if (pready)
            begin
                prep    <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Output latch and control
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            latch <= `ODP_LATCH_RST;
        else if (ce && wr_done)
        begin
            if (hit(idx, `ODP_IDX_OUT_LO))
                latch[15:0] <= merge16(latch[15:0], pwdata[15:0], pstrb[1:0]);
            else if (hit(idx, `ODP_IDX_OUT_HI) && pstrb[0])
                latch[23:16] <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ctrl <= `ODP_CTRL_RST;
        else if (ce && wr_done && hit(idx, `ODP_IDX_CTRL) && pstrb[0])
            ctrl <= pwdata[`ODP_CTRL_WIDTH-1:0];
    end

    // ****************************************************************
    // Drivers and direct read
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            drive <= `ODP_LATCH_RST;
        else if (ce && (!ctrl.dbl_buf || strobe))
            drive <= latch;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            din <= `ODP_LATCH_RST;
        else if (ce && (!ctrl.dbl_buf || strobe))
            din <= pin_s;
    end

    // Re-driven clock passes the synchroniser, so it lags ext_clk by a
    // few bus cycles; all modules still share the same copy.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mclk_oe <= 1'b0;
        else if (ce)
            mclk_oe <= ctrl.mode_en & ctrl.master_sel & ~ext_lvl_s;
    end

    always_comb
    begin
        pin_oe = ~drive;
        if (ctrl.mode_en && ctrl.master_sel)
            pin_oe[`ODP_MCLK_OUT_LINE] = mclk_oe;
    end

    // Open drain: only ever pulls low
    assign pin_out = '0;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_rd_setup(logic [5:0] r);
        psel && !prep && !pwrite && ce && hit(idx, r);
    endsequence

    sequence s_full_wr(logic [5:0] r);
        pready && pwrite && hit(idx, r) && pstrb[1:0] == 2'b11;
    endsequence

    chk_reset_ones: assert property (@(posedge ref_clk)
        srst |=> latch == `ODP_LATCH_RST && pin_oe == 24'h000000)
        else $error("latch not all ones after reset");

    chk_out_follow: assert property (@(posedge ref_clk) disable iff (srst)
        s_full_wr(`ODP_IDX_OUT_LO) && !ctrl.dbl_buf ##1 ce
        |=> pin_oe[15:0] == ~$past(pwdata[15:0], 2))
        else $error("driver does not follow written latch");

    chk_readback: assert property (@(posedge ref_clk) disable iff (srst)
        s_rd_setup(`ODP_IDX_OUT_LO) |=> prdata == {16'h0000, $past(latch[15:0])})
        else $error("read back differs from latch");

    chk_direct_read: assert property (@(posedge ref_clk) disable iff (srst)
        s_rd_setup(`ODP_IDX_DIR_LO) |=> prdata[15:0] == $past(din[15:0]))
        else $error("direct read differs from sampled pins");

    chk_hi_zero: assert property (@(posedge ref_clk) disable iff (srst)
        s_rd_setup(`ODP_IDX_OUT_HI) |=> prdata[31:8] == 24'h000000)
        else $error("upper bits of high word not zero");

    chk_ctrl_upper: assert property (@(posedge ref_clk) disable iff (srst)
        s_rd_setup(`ODP_IDX_CTRL) |=> prdata[31:4] == 28'h0000000)
        else $error("control upper bits not zero");

    chk_db_hold: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl.dbl_buf && !strobe |=> $stable(drive))
        else $error("driver changed without latch edge");

    chk_db_update: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl.dbl_buf && strobe && ce |=> drive == $past(latch))
        else $error("latch edge did not load drivers");

    chk_byte_lane: assert property (@(posedge ref_clk) disable iff (srst)
        pready && pwrite && hit(idx, `ODP_IDX_OUT_LO) && pstrb[1:0] == 2'b01
        |=> $stable(latch[15:8]))
        else $error("unstrobed byte lane was written");

    chk_master_out: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl.mode_en && ctrl.master_sel && ce ##1 ctrl.mode_en && ctrl.master_sel
        |-> pin_oe[`ODP_MCLK_OUT_LINE] == !$past(ext_lvl_s))
        else $error("master clock not re-driven on line 23");

    chk_answer_time: assert property (@(posedge ref_clk) disable iff (srst)
        psel && !penable && !prep && ce ##1 penable && ce |-> pready)
        else $error("access phase not answered at once");

endmodule : odp_port
`default_nettype wire

// file: testbench/odp_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Field wiring: pull-ups, field drivers, master clock link
// ********
module odp_field_model (
    // Design side
    input  wire odp_pkg::odp_lines_t pin_out,
    input  wire odp_pkg::odp_lines_t pin_oe,
    // Field side
    input  wire odp_pkg::odp_lines_t field_low,
    input  wire logic                link_en,
    output odp_pkg::odp_lines_t      pin_in
);
    import odp_pkg::*;
    odp_lines_t lvl;

    always_comb
    begin
        // Released lines float up on the pull-up, never hold the last value
        for (int i = 0; i < 24; i++)
            lvl[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & ~field_low[i];
        pin_in = lvl;
        // Wired-AND of line 23 onto line 24 when the link is fitted
        if (link_en)
            pin_in[23] = lvl[22] & lvl[23];
    end
endmodule : odp_field_model
`default_nettype wire

// file: testbench/odp_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "odp_params.svh"
module odp_port_tb_top;
    import odp_pkg::*;
    // ********
    // Signals
    // ********
    localparam logic [7:0] A_OLO = {`ODP_IDX_OUT_LO, 2'b00};
    localparam logic [7:0] A_OHI = {`ODP_IDX_OUT_HI, 2'b00};
    localparam logic [7:0] A_DLO = {`ODP_IDX_DIR_LO, 2'b00};
    localparam logic [7:0] A_DHI = {`ODP_IDX_DIR_HI, 2'b00};
    localparam logic [7:0] A_CTL = {`ODP_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_BAD = 8'h3C;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        ext_clk = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    odp_lines_t  pin_in;
    odp_lines_t  pin_out;
    odp_lines_t  pin_oe;
    odp_lines_t  field_low = 24'h0;
    logic        link_en = 1'b0;
    logic [15:0] cur_oe;
    int          n_errors = 0;
    int          n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    odp_port u_odp_port (.ref_clk(ref_clk), .srst(srst), .ce(ce), .ext_clk(ext_clk),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    odp_field_model u_odp_field_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .field_low(field_low), .link_en(link_en), .pin_in(pin_in));

    // ********
    // Compare and bus tasks
    // ********
    task automatic chk_data(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_data

    task automatic chk_flag(string nm, logic e, logic g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_flag

    task automatic chk_pins(string nm, odp_lines_t e, odp_lines_t g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pins

    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
                       logic [31:0] e, logic ee);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1);
        // Access phase must be answered with no wait state while ce is high
        chk_flag($sformatf("pready wait@%h", a), 1'b1, n == 1);
        if (!w)
            chk_data($sformatf("prdata@%h", a), e, prdata);
        chk_flag($sformatf("pslverr@%h", a), ee, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
        apb(1'b1, a, d, s, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0, e, 1'b0);
    endtask : rd

    // Edges stay many bus cycles apart, far below the clock ceiling, save the ce freeze pair, which falls one bus cycle apart
    task automatic ext_to(logic v);
        @(posedge ref_clk);
        #7 ext_clk = v;
    endtask : ext_to

    task automatic db_step(logic [15:0] v, logic lvl, logic upd);
        wr(A_OLO, {16'h0, v}, 4'h3);
        cyc(10);
        chk_pins("pin_oe staged", {8'h00, cur_oe}, {8'h00, pin_oe[15:0]});
        ext_to(lvl);
        cyc(14);
        if (upd)
            cur_oe = ~v;
        chk_pins("pin_oe latched", {8'h00, cur_oe}, {8'h00, pin_oe[15:0]});
    endtask : db_step

    task automatic print_verdict;
        $display("Errors %0d Tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // ********
    // Tests
    // ********
    initial
    begin
        cyc(5000);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        // Three link rises inside reset so that side resets too
        repeat (6) #7.5 ext_clk = ~ext_clk;
        cyc(3);
        srst <= 1'b0;
        // The link side leaves reset only after two more of its own rises
        repeat (4) #7.5 ext_clk = ~ext_clk;
        rd(A_OLO, 32'h0000FFFF);
        rd(A_OHI, 32'h000000FF);
        rd(A_CTL, 32'h0);
        chk_pins("pin_oe reset", 24'h0, pin_oe);
        rd(A_DLO, 32'h0000FFFF);
        wr(A_OLO, 32'h1234, 4'h3);
        rd(A_OLO, 32'h1234);
        cyc(6);
        chk_pins("pin_oe drive", 24'h00EDCB, pin_oe);
        rd(A_DLO, 32'h1234);
        wr(A_OLO, 32'hAB00, 4'h2);
        wr(A_OLO, 32'h00CD, 4'h1);
        rd(A_OLO, 32'hABCD);
        wr(A_OHI, 32'hFF5A, 4'h3);
        rd(A_OHI, 32'h5A);
        cyc(6);
        rd(A_DHI, 32'h5A);
        wr(A_OLO, 32'hFFFF, 4'h3);
        wr(A_OHI, 32'hFF, 4'h1);
        field_low[3:0] <= 4'hF;
        cyc(6);
        rd(A_DLO, 32'hFFF0);
        rd(A_OLO, 32'hFFFF);
        field_low <= 24'h0;
        apb(1'b1, A_DLO, 32'h0, 4'h3, 32'h0, 1'b1);
        apb(1'b0, A_BAD, 32'h0, 4'h0, 32'h0, 1'b1);
        cyc(6);
        rd(A_DLO, 32'hFFFF);
        wr(A_CTL, 32'hFFFF, 4'h3);
        rd(A_CTL, 32'hF);
        // Leave master mode first so line 23 is released before staging starts
        wr(A_CTL, 32'h0, 4'h1);
        cyc(6);
        wr(A_CTL, 32'h1, 4'h1);
        cyc(12);
        cur_oe = 16'h0;
        field_low[16] <= 1'b1;
        cyc(10);
        rd(A_DHI, 32'hFF);
        db_step(16'h00FF, 1'b1, 1'b1);
        rd(A_DHI, 32'hFE);
        field_low <= 24'h0;
        db_step(16'h0F0F, 1'b0, 1'b0);
        db_step(16'h3C3C, 1'b1, 1'b1);
        wr(A_CTL, 32'h3, 4'h1);
        cyc(12);
        db_step(16'h5555, 1'b0, 1'b1);
        db_step(16'hAAAA, 1'b1, 1'b0);
        db_step(16'h6666, 1'b0, 1'b1);
        // Clock enable low freezes the crossing, so the edge waits for ce
        wr(A_OLO, 32'h4444, 4'h3);
        ce <= 1'b0;
        ext_to(1'b1);
        ext_to(1'b0);
        cyc(14);
        chk_pins("pin_oe frozen", {8'h00, cur_oe}, {8'h00, pin_oe[15:0]});
        ce <= 1'b1;
        cyc(14);
        cur_oe = 16'hBBBB;
        chk_pins("pin_oe thawed", {8'h00, cur_oe}, {8'h00, pin_oe[15:0]});
        link_en <= 1'b1;
        wr(A_CTL, 32'hC, 4'h1);
        cyc(6);
        chk_flag("line 23 drive", 1'b1, pin_oe[22]);
        ext_to(1'b1);
        cyc(6);
        chk_flag("line 23 drive", 1'b0, pin_oe[22]);
        wr(A_CTL, 32'hD, 4'h1);
        cyc(12);
        db_step(16'h1111, 1'b0, 1'b0);
        db_step(16'h2222, 1'b1, 1'b1);
        wr(A_CTL, 32'h0, 4'h1);
        print_verdict();
    end
endmodule : odp_port_tb_top
`default_nettype wire
